// ---- nvsram_ctrl_regs.svh ----
// Purpose: constants for the nonvolatile sram host controller
// Assumes: 50 MHz clk_sys, 20 ns period
// Notes: timing counts are rounded up to whole clk_sys cycles
// Function
// RULE_01 - host keeps write strobe high on reads, low on writes
// RULE_02 - device floats outputs when write strobe low as chip select falls
// RULE_03 - save command: six reads 0E38 31C7 03E0 3C1F 303F 0FC0
// RULE_04 - restore command: six reads 0E38 31C7 03E0 3C1F 303F 0C63
// RULE_05 - only consecutive reads in the listed order form a command
// RULE_06 - write strobe stays high through all six command reads
// RULE_07 - only lower 14 address bits matter for command matching
// RULE_08 - each command read framed by chip select low then high
// RULE_09 - first five reads return data, sixth floats and starts operation
// RULE_10 - power-up restore finishes within 550 us after supply trip
// RULE_11 - any other access in between abandons the command
// RULE_12 - bus ignored during save until save duration elapsed
// RULE_13 - power-down save skipped unless written; commanded save always runs (nvsram_dev has no power-down save and saves only while supply_ok is high)
// RULE_14 - below trip level saves and writes are blocked
// RULE_15 - bus refused during commanded restore until restore duration elapsed
`ifndef NVSRAM_CTRL_REGS_SVH
`define NVSRAM_CTRL_REGS_SVH
`define SEQ_ADDR_0 14'h0E38
`define SEQ_ADDR_1 14'h31C7
`define SEQ_ADDR_2 14'h03E0
`define SEQ_ADDR_3 14'h3C1F
`define SEQ_ADDR_4 14'h303F
`define SEQ_ADDR_SAVE 14'h0FC0
`define SEQ_ADDR_RESTORE 14'h0C63
`define CLK_PERIOD_NS 20
`define SAVE_DURATION_MS 10
`define RESTORE_DURATION_US 20
`define POWERUP_RESTORE_DURATION_US 550
`define SAVE_CYCLES ((`SAVE_DURATION_MS * 1000000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESTORE_CYCLES ((`RESTORE_DURATION_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWERUP_CYCLES ((`POWERUP_RESTORE_DURATION_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYCLES 2
`define STROBE_CYCLES 3
`define HOLD_CYCLES 2
`endif

// ---- nvsram_ctrl_pkg.sv ----
package nvsram_ctrl_pkg;
    typedef enum logic [1:0] {op_read, op_write, op_save, op_restore} op_t;
    typedef struct packed {
        op_t op;
        logic [14:0] addr;
        logic [7:0] data;
    } req_t;
    typedef struct packed {
        logic [14:0] location_bus;
        logic [7:0] io_out;
        logic io_oe;
        logic chip_sel_b;
        logic write_b;
        logic out_en_b;
    } pins_t;
endpackage

// ---- nvsram_host.sv ----
// Purpose: host controller driving a nonvolatile sram through its pins
// Assumes: pins timed at clk_sys; device meets its access times within strobe
// Notes: one request at a time; commands issue six reads back to back
`timescale 1ns/1ns
`include "nvsram_ctrl_regs.svh"
`default_nettype none
module nvsram_host
    import nvsram_ctrl_pkg::*;
#(
    parameter int unsigned SAVE_WAIT = `SAVE_CYCLES,
    parameter int unsigned RESTORE_WAIT = `RESTORE_CYCLES,
    parameter int unsigned POWERUP_WAIT = `POWERUP_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire req_t req,
    input wire logic supply_ok,
    input wire logic [7:0] io_bus_in,
    output logic req_ready,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output var pins_t pins
);
    typedef enum logic [2:0] {s_power, s_idle, s_setup, s_strobe, s_hold, s_busy} state_t;

    function automatic logic [13:0] seq_addr(input logic [2:0] idx, input op_t op);
        case (idx)
            3'h0: seq_addr = `SEQ_ADDR_0;
            3'h1: seq_addr = `SEQ_ADDR_1;
            3'h2: seq_addr = `SEQ_ADDR_2;
            3'h3: seq_addr = `SEQ_ADDR_3;
            3'h4: seq_addr = `SEQ_ADDR_4;
            default: seq_addr = (op == op_save) ? `SEQ_ADDR_SAVE : `SEQ_ADDR_RESTORE;
        endcase
    endfunction

    function automatic logic is_nv_cmd(input op_t op);
        is_nv_cmd = (op == op_save) || (op == op_restore);
    endfunction

    function automatic logic count_done(input logic [19:0] count, input logic [19:0] limit);
        count_done = (count + 20'h0_0001) >= limit;
    endfunction

    logic [7:0] io_s1, io_s2;
    logic ok_s1, ok_s2;
    logic [7:0] next_io_s1, next_io_s2;
    logic next_ok_s1, next_ok_s2;
    logic [19:0] busy_limit;
    state_t state, next_state;
    req_t cur, next_cur;
    logic [2:0] step, next_step;
    logic [19:0] cnt, next_cnt;
    logic next_req_ready, next_rsp_valid;
    logic [7:0] next_rsp_data;
    pins_t next_pins;

    // both inputs arrive from outside clk_sys, so two flops before use
    always_comb begin
        next_io_s1 = io_bus_in;
        next_io_s2 = io_s1;
        next_ok_s1 = supply_ok;
        next_ok_s2 = ok_s1;
    end

    always_ff @(posedge clk_sys) begin
        io_s1 <= next_io_s1;
        io_s2 <= next_io_s2;
        ok_s1 <= next_ok_s1;
        ok_s2 <= next_ok_s2;
    end

    // save runs far longer than restore, so each has its own wait
    assign busy_limit = (cur.op == op_save) ? 20'(SAVE_WAIT) : 20'(RESTORE_WAIT);

    always_comb begin
        next_state = state;
        next_cur = cur;
        next_step = step;
        next_cnt = cnt;
        next_req_ready = 1'b0;
        next_rsp_valid = 1'b0;
        next_rsp_data = rsp_data;
        next_pins = pins;
        case (state)
            s_power: begin
                // wait out power-up restore before any access
                next_pins.chip_sel_b = 1'b1; // RULE_10
                next_pins.write_b = 1'b1;
                next_pins.io_oe = 1'b0;
                next_pins.out_en_b = 1'b1;
                if (!ok_s2) begin
                    next_cnt = 20'h0_0000;
                end else if (cnt >= 20'(POWERUP_WAIT)) begin
                    next_state = s_idle;
                    next_req_ready = 1'b1;
                end else begin
                    next_cnt = cnt + 20'h0_0001;
                end
            end
            s_idle: begin
                next_req_ready = 1'b1;
                if (!ok_s2) begin
                    // writes and saves are useless below trip level
                    next_state = s_power; // RULE_14
                    next_cnt = 20'h0_0000;
                    next_req_ready = 1'b0;
                end else if (req_valid) begin
                    next_req_ready = 1'b0;
                    next_cur = req;
                    next_step = 3'h0;
                    next_state = s_setup;
                    next_cnt = 20'h0_0000;
                end
            end
            s_setup: begin
                // address settles before chip select falls
                if (is_nv_cmd(cur.op)) begin
                    next_pins.location_bus = {cur.addr[14], seq_addr(step, cur.op)}; // RULE_03 RULE_04 RULE_07
                end else begin
                    next_pins.location_bus = cur.addr;
                end
                // write strobe set before chip select, high for reads
                next_pins.write_b = (cur.op == op_write) ? 1'b0 : 1'b1; // RULE_01 RULE_06
                next_pins.io_out = cur.data;
                next_pins.io_oe = (cur.op == op_write);
                next_pins.out_en_b = (cur.op == op_write);
                next_cnt = cnt + 20'h0_0001;
                if (count_done(cnt, 20'(`SETUP_CYCLES))) begin
                    next_state = s_strobe;
                    next_cnt = 20'h0_0000;
                    next_pins.chip_sel_b = 1'b0; // RULE_08
                end
                if (cur.op == op_write && !ok_s2) begin
                    // supply sagged: drop the write before chip select ever falls
                    next_state = s_power; // RULE_14
                    next_cnt = 20'h0_0000;
                    next_pins.chip_sel_b = 1'b1;
                    next_pins.write_b = 1'b1;
                    next_pins.io_oe = 1'b0;
                    next_rsp_valid = 1'b1;
                end
            end
            s_strobe: begin
                next_cnt = cnt + 20'h0_0001;
                if (count_done(cnt, 20'(`STROBE_CYCLES))) begin
                    next_pins.chip_sel_b = 1'b1; // RULE_08
                    next_state = s_hold;
                    next_cnt = 20'h0_0000;
                    next_rsp_data = io_s2;
                end
            end
            s_hold: begin
                next_pins.out_en_b = 1'b1;
                next_cnt = cnt + 20'h0_0001;
                if (count_done(cnt, 20'(`HOLD_CYCLES))) begin
                    next_pins.io_oe = 1'b0;
                    next_pins.write_b = 1'b1;
                    next_cnt = 20'h0_0000;
                    if (is_nv_cmd(cur.op) && step != 3'h5) begin
                        // no other access is allowed between command reads
                        next_step = step + 3'h1; // RULE_05 RULE_11
                        next_state = s_setup;
                    end else if (is_nv_cmd(cur.op)) begin
                        // device floats on the sixth read and goes busy
                        next_state = s_busy; // RULE_09 RULE_13
                    end else begin
                        next_state = s_idle;
                        next_rsp_valid = 1'b1;
                        next_req_ready = 1'b1;
                    end
                end
            end
            s_busy: begin
                // bus held idle, device ignores inputs meanwhile
                next_cnt = cnt + 20'h0_0001; // RULE_12 RULE_15
                next_pins.chip_sel_b = 1'b1;
                next_pins.out_en_b = 1'b1;
                if (count_done(cnt, busy_limit)) begin
                    next_state = s_idle;
                    next_rsp_valid = 1'b1;
                    next_req_ready = 1'b1;
                    next_cnt = 20'h0_0000;
                end
            end
            default: begin
                // unknown state: release the bus and start over
                next_state = s_power;
                next_cnt = 20'h0_0000;
                next_pins.chip_sel_b = 1'b1;
                next_pins.write_b = 1'b1;
                next_pins.io_oe = 1'b0;
                next_pins.out_en_b = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state <= s_power;
            cur <= '0;
            step <= 3'h0;
            cnt <= 20'h0_0000;
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            pins.location_bus <= 15'h0000;
            pins.io_out <= 8'h00;
            pins.io_oe <= 1'b0;
            pins.chip_sel_b <= 1'b1;
            pins.write_b <= 1'b1;
            pins.out_en_b <= 1'b1;
        end else begin
            state <= next_state;
            cur <= next_cur;
            step <= next_step;
            cnt <= next_cnt;
            req_ready <= next_req_ready;
            rsp_valid <= next_rsp_valid;
            rsp_data <= next_rsp_data;
            pins <= next_pins;
        end
    end
endmodule
`default_nettype wire

// ---- nvsram_host_props.sv ----
// Purpose: pin checks for nvsram_host
// Assumes: bench wait parameters 20 and 10
// Notes: bound of 40 fits small waits only
`timescale 1ns/1ns
`include "nvsram_ctrl_regs.svh"
`default_nettype none
module nvsram_host_props
    import nvsram_ctrl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire req_t req,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic supply_ok,
    input wire pins_t pins
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence frame(logic [13:0] a);
        ##[1:8] ($fell(pins.chip_sel_b) && pins.write_b && pins.location_bus[13:0] == a);
    endsequence
    property cmd_p(op_t o, logic [13:0] last);
        req_valid && req_ready && req.op == o |-> frame(`SEQ_ADDR_0) ##0 frame(`SEQ_ADDR_1) ##0 frame(`SEQ_ADDR_2)
            ##0 frame(`SEQ_ADDR_3) ##0 frame(`SEQ_ADDR_4) ##0 frame(last) ##3 (pins.chip_sel_b throughout ##[1:40] rsp_valid);
    endproperty
    AST_READ_KEEPS_WRITE_HIGH: assert property (!pins.chip_sel_b |-> pins.write_b == !pins.io_oe)
        else $error("write strobe does not match bus direction");
    AST_SELECT_FRAME: assert property ($fell(pins.chip_sel_b) |-> !pins.chip_sel_b [*3] ##1 pins.chip_sel_b)
        else $error("chip select frame not three cycles");
    AST_ADDR_HELD: assert property (!pins.chip_sel_b |-> $stable(pins.location_bus))
        else $error("address moved under chip select");
    AST_SAVE_CMD: assert property (cmd_p(op_save, `SEQ_ADDR_SAVE))
        else $error("save sequence wrong");
    AST_RESTORE_CMD: assert property (cmd_p(op_restore, `SEQ_ADDR_RESTORE))
        else $error("restore sequence wrong");
    AST_LOW_SUPPLY_IDLE: assert property (!supply_ok [*6] |-> !req_ready && pins.chip_sel_b)
        else $error("bus active below trip level");
endmodule
`default_nettype wire

// ---- nvsram_dev.sv ----
// Purpose: behavioural nonvolatile sram on the host pins
// Assumes: busy time shorter than host waits
// Notes: released bus shows inverted cell data, never stale data
`timescale 1ns/1ns
`include "nvsram_ctrl_regs.svh"
`default_nettype none
module nvsram_dev
    import nvsram_ctrl_pkg::*;
#(
    parameter int BUSY_NS = 150
) (
    input wire pins_t pins,
    input wire logic supply_ok,
    output logic [7:0] dq
);
    logic [7:0] mem [0:32767];
    logic [7:0] nv [0:32767];
    logic [13:0] key [0:4] = '{`SEQ_ADDR_0, `SEQ_ADDR_1, `SEQ_ADDR_2, `SEQ_ADDR_3, `SEQ_ADDR_4};
    logic [13:0] a;
    logic quiet = 1'b0;
    logic busy = 1'b0;
    int step = 0;
    wire logic drive = !pins.chip_sel_b && !pins.out_en_b && !quiet && !busy;
    assign dq = drive ? mem[pins.location_bus] : ~mem[pins.location_bus];
    always @(posedge pins.chip_sel_b)
        if (!pins.write_b && !busy && supply_ok) mem[pins.location_bus] = pins.io_out;
    always @(negedge pins.chip_sel_b) begin
        a = pins.location_bus[13:0];
        quiet = !pins.write_b || busy;
        if (quiet) step = 0;
        else if (step == 5 && (a == `SEQ_ADDR_SAVE || a == `SEQ_ADDR_RESTORE)) begin
            quiet = 1'b1;
            step = 0;
            if (a == `SEQ_ADDR_RESTORE) mem = nv;
            else if (supply_ok) nv = mem;
            busy = 1'b1;
            #(BUSY_NS) busy = 1'b0;
        end else if (step < 5 && a == key[step]) step++;
        else step = int'(a == `SEQ_ADDR_0);
    end
    always @(posedge supply_ok) begin
        mem = nv;
        busy = 1'b1;
        #(BUSY_NS) busy = 1'b0;
    end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Purpose: self-checking bench for nvsram_host
// Assumes: small wait parameters, device model on pins
// Notes: brownout drops supply with a write pending
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; $display("unexpected %0t: %h vs %h", $time, g, e); end end
module testbench
    import nvsram_ctrl_pkg::*;
;
    logic clk_sys = 1'b0, rst_b = 1'b0, req_valid = 1'b0, supply_ok = 1'b1;
    req_t req = '0;
    logic req_ready, rsp_valid;
    logic [7:0] rsp_data, dq;
    pins_t pins;
    int errors = 0, checked = 0;
    nvsram_host #(.SAVE_WAIT(20), .RESTORE_WAIT(10), .POWERUP_WAIT(10)) nvsram_host_i (.clk_sys(clk_sys),
        .rst_b(rst_b), .req_valid(req_valid), .req(req), .supply_ok(supply_ok), .io_bus_in(dq),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins));
    nvsram_dev nvsram_dev_i (.pins(pins), .supply_ok(supply_ok), .dq(dq));
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic tally_and_finish;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic do_req(input op_t o, input logic [14:0] a, input logic [7:0] d);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 2000) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 2000) errors++;
        req <= '{o, a, d};
        req_valid <= 1'b1;
        @(posedge clk_sys);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (rsp_valid !== 1'b1 && n < 2000);
        if (n >= 2000) errors++;
    endtask
    task automatic t_rw;
        do_req(op_write, 15'h0005, 8'h3c);
        do_req(op_write, 15'h7fff, 8'hc3);
        do_req(op_read, 15'h0005, 8'h00);
        `CHK(rsp_data, 8'h3c)
        do_req(op_read, 15'h7fff, 8'h00);
        `CHK(rsp_data, 8'hc3)
    endtask
    task automatic t_nv;
        do_req(op_save, 15'h4000, 8'h00);
        do_req(op_write, 15'h0005, 8'h99);
        do_req(op_restore, 15'h0000, 8'h00);
        do_req(op_read, 15'h0005, 8'h00);
        `CHK(rsp_data, 8'h3c)
        do_req(op_read, 15'h7fff, 8'h00);
        `CHK(rsp_data, 8'hc3)
    endtask
    task automatic t_brown;
        supply_ok <= 1'b0;
        req <= '{op_write, 15'h0005, 8'h11};
        req_valid <= 1'b1;
        repeat (8) @(posedge clk_sys);
        `CHK(req_ready, 1'b0)
        `CHK(pins.chip_sel_b, 1'b1)
        req_valid <= 1'b0;
        supply_ok <= 1'b1;
        do_req(op_read, 15'h0005, 8'h00);
        `CHK(rsp_data, 8'h3c)
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_rw;
        t_nv;
        t_brown;
        tally_and_finish;
    end
    initial begin
        #100_000;
        errors++;
        tally_and_finish;
    end
endmodule
bind nvsram_host nvsram_host_props nvsram_host_props_i (.clk_sys(clk_sys), .rst_b(rst_b), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .supply_ok(supply_ok), .pins(pins));
`default_nettype wire
